// file: src/pirq_pkg.sv
// Package with register offsets, bit layouts and reset values of the peripheral interrupt unit.
package pirq_pkg;

    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 8;
    localparam int NUM_REGS = 4;

    // Register offsets on the software port.
    localparam logic [3:0] OFF_CORE_IRQ_CONTROL = 4'h0;
    localparam logic [3:0] OFF_ENABLE_1 = 4'h1;
    localparam logic [3:0] OFF_ENABLE_2 = 4'h2;
    localparam logic [3:0] OFF_ENABLE_3 = 4'h3;
    localparam logic [3:0] OFF_ENABLE_4 = 4'h4;
    localparam logic [3:0] OFF_REQUEST_1 = 4'h5;
    localparam logic [3:0] OFF_REQUEST_2 = 4'h6;
    localparam logic [3:0] OFF_REQUEST_3 = 4'h7;
    localparam logic [3:0] OFF_REQUEST_4 = 4'h8;
    localparam logic [3:0] OFF_EVT_STATUS = 4'h9;
    localparam logic [3:0] OFF_EVT_CLEAR = 4'ha;
    localparam logic [3:0] OFF_EVT_ENABLE = 4'hb;

    // Bit positions in the core interrupt control register.
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_PERIPH_IRQ_MASTER_ENABLE = 6;

    // Implemented bits of each enable/request pair, larger variant.
    localparam logic [7:0] MASK_REG_1 = 8'hff;
    localparam logic [7:0] MASK_REG_2 = 8'hf9;
    localparam logic [7:0] MASK_REG_3 = 8'h3a;
    localparam logic [7:0] MASK_REG_4 = 8'h03;
    // Bits of the second pair that exist only on the larger variant.
    localparam logic [7:0] LARGE_ONLY_2 = 8'h01;

    // Request bits software cannot write (receive and transmit flags).
    localparam logic [7:0] READ_ONLY_REQ_1 = 8'h30;

    // Bit positions of the serial port 2 flags in the fourth request register.
    localparam int BIT_SERIAL2_COLLISION = 1;
    localparam int BIT_SERIAL2_EVENT = 0;

    // Event status bits of the interrupt event register.
    localparam int EVT_BIT_VECTOR_TAKEN = 0;
    localparam int EVT_BIT_REQ_RISE = 1;
    localparam int EVT_WIDTH = 2;

    // Interrupt vector address.
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_EVT = 2'h0;

endpackage

// file: src/pirq_flag_reg.sv
// One enable/request register pair with masked set, clear and read paths.
`timescale 1ns/100ps
module pirq_flag_reg
    import pirq_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hff,
    parameter logic [7:0] RO_MASK = 8'h00
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] hw_set,
    input wire logic [7:0] hw_hold_low,
    input wire logic en_write,
    input wire logic req_write,
    input wire logic [7:0] wr_data,
    output logic [7:0] enable,
    output logic [7:0] request,
    output logic active
);

    // Enable bits follow software writes; unimplemented bits stay zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable <= RESET_BYTE;
        end else if (en_write) begin
            enable <= wr_data & IMPL_MASK;
        end
    end

    // Flags are set by hardware events whatever any enable holds; set wins over clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            request <= RESET_BYTE;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!IMPL_MASK[i]) begin
                    request[i] <= 1'b0;
                end else if (hw_set[i]) begin
                    request[i] <= 1'b1;
                end else if (hw_hold_low[i]) begin
                    request[i] <= 1'b0;
                end else if (req_write && !RO_MASK[i]) begin
                    request[i] <= wr_data[i];
                end
            end
        end
    end

    // Pending and enabled sources of this pair.
    assign active = |(request & enable);

endmodule // pirq_flag_reg

// file: src/pirq_unit.sv
// Peripheral interrupt enable/request registers with core gating and vector request.
// Overview of operation
// - No peripheral interrupt without master enable.
// - Flags set on events regardless of enables.
// - Second enable register bit layout.
// - Third enable register bit layout.
// - Fourth enable register bit layout.
// - First request register layout, two read-only.
// - Second request register mirrors second enable.
// - Third request register mirrors third enable.
// - Serial 2 collision flag set by hardware.
// - Serial 2 event flag, zero while pending.
// - One enables or pends, zero does not.
// - All bits reset to zero.
// - Unimplemented bits ignore writes, read zero.
// - Registers three, four exist on larger variant.
// - Global enable clear holds requests until set.
// - Taken interrupt branches to vector 0004h.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module pirq_unit
    import pirq_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] event_1,
    input wire logic [7:0] event_2,
    input wire logic [7:0] event_3,
    input wire logic [7:0] event_4,
    input wire logic serial2_busy,
    input wire logic irq_ack,
    output logic core_irq,
    output logic [15:0] vector_addr,
    output logic irq_line
);

    initial begin
        if (LARGE_VARIANT !== 1'b0 && LARGE_VARIANT !== 1'b1) begin
            $error("LARGE_VARIANT must be 0 or 1");
        end
    end

    // Variant-dependent implemented masks.
    localparam logic [7:0] IMPL_2 = LARGE_VARIANT ? MASK_REG_2 : (MASK_REG_2 & ~LARGE_ONLY_2);
    localparam logic [7:0] IMPL_3 = LARGE_VARIANT ? MASK_REG_3 : 8'h00;
    localparam logic [7:0] IMPL_4 = LARGE_VARIANT ? MASK_REG_4 : 8'h00;

    logic [7:0] core_ctrl;
    logic [7:0] en_1, en_2, en_3, en_4;
    logic [7:0] rq_1, rq_2, rq_3, rq_4;
    logic act_1, act_2, act_3, act_4;
    logic periph_pending;
    logic periph_req;
    logic [EVT_WIDTH-1:0] evt_status;
    logic [EVT_WIDTH-1:0] evt_enable;
    logic periph_req_q;
    logic [7:0] next_rdata;
    logic [7:0] hold_4;
    logic taken;

    // Decoded write strobes per register.
    logic wr_ctrl, wr_e1, wr_e2, wr_e3, wr_e4, wr_r1, wr_r2, wr_r3, wr_r4;
    logic wr_clr, wr_evt_en;
    assign wr_ctrl = reg_write && reg_addr == OFF_CORE_IRQ_CONTROL;
    assign wr_e1 = reg_write && reg_addr == OFF_ENABLE_1;
    assign wr_e2 = reg_write && reg_addr == OFF_ENABLE_2;
    assign wr_e3 = reg_write && reg_addr == OFF_ENABLE_3;
    assign wr_e4 = reg_write && reg_addr == OFF_ENABLE_4;
    assign wr_r1 = reg_write && reg_addr == OFF_REQUEST_1;
    assign wr_r2 = reg_write && reg_addr == OFF_REQUEST_2;
    assign wr_r3 = reg_write && reg_addr == OFF_REQUEST_3;
    assign wr_r4 = reg_write && reg_addr == OFF_REQUEST_4;
    assign wr_clr = reg_write && reg_addr == OFF_EVT_CLEAR;
    assign wr_evt_en = reg_write && reg_addr == OFF_EVT_ENABLE;

    // The serial 2 event flag is forced low while its operation runs, except in a cycle where its event sets it.
    assign hold_4 = {6'h00, 1'b0, serial2_busy};

    // Register pairs; masks give each pair its layout.
    pirq_flag_reg #(.IMPL_MASK(MASK_REG_1), .RO_MASK(READ_ONLY_REQ_1)) u_pair_1 (
        .clk_sys(clk_sys), .rst(rst), .hw_set(event_1), .hw_hold_low(8'h00),
        .en_write(wr_e1), .req_write(wr_r1), .wr_data(reg_wdata),
        .enable(en_1), .request(rq_1), .active(act_1));
    pirq_flag_reg #(.IMPL_MASK(IMPL_2), .RO_MASK(8'h00)) u_pair_2 (
        .clk_sys(clk_sys), .rst(rst), .hw_set(event_2), .hw_hold_low(8'h00),
        .en_write(wr_e2), .req_write(wr_r2), .wr_data(reg_wdata),
        .enable(en_2), .request(rq_2), .active(act_2));
    pirq_flag_reg #(.IMPL_MASK(IMPL_3), .RO_MASK(8'h00)) u_pair_3 (
        .clk_sys(clk_sys), .rst(rst), .hw_set(event_3), .hw_hold_low(8'h00),
        .en_write(wr_e3), .req_write(wr_r3), .wr_data(reg_wdata),
        .enable(en_3), .request(rq_3), .active(act_3));
    pirq_flag_reg #(.IMPL_MASK(IMPL_4), .RO_MASK(8'h00)) u_pair_4 (
        .clk_sys(clk_sys), .rst(rst), .hw_set(event_4), .hw_hold_low(hold_4),
        .en_write(wr_e4), .req_write(wr_r4), .wr_data(reg_wdata),
        .enable(en_4), .request(rq_4), .active(act_4));

    // Combined peripheral request, gated by master enable and then global enable.
    assign periph_pending = act_1 | act_2 | act_3 | act_4;
    assign periph_req = periph_pending && core_ctrl[BIT_PERIPH_IRQ_MASTER_ENABLE];
    assign taken = core_irq && irq_ack;

    // Core control holds the two enables; taking an interrupt clears global enable.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_ctrl <= RESET_BYTE;
        end else if (wr_ctrl) begin
            core_ctrl <= reg_wdata & 8'hc0;
        end else if (taken) begin
            core_ctrl[BIT_GLOBAL_IRQ_ENABLE] <= 1'b0;
        end
    end

    // Request to the core waits for global enable; a held request fires once it is set.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_irq <= 1'b0;
        end else begin
            core_irq <= periph_req && core_ctrl[BIT_GLOBAL_IRQ_ENABLE] && !taken;
        end
    end

    // Vector address presented on the cycle after a taken interrupt.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vector_addr <= 16'h0000;
        end else if (taken) begin
            vector_addr <= IRQ_VECTOR;
        end
    end

    // Edge memory for the request rise event.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            periph_req_q <= 1'b0;
        end else begin
            periph_req_q <= periph_req;
        end
    end

    // Sticky event status; a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evt_status <= RESET_EVT;
        end else begin
            for (int i = 0; i < EVT_WIDTH; i++) begin
                if ((i == EVT_BIT_VECTOR_TAKEN && taken) ||
                    (i == EVT_BIT_REQ_RISE && periph_req && !periph_req_q)) begin
                    evt_status[i] <= 1'b1;
                end else if (wr_clr && reg_wdata[i]) begin
                    evt_status[i] <= 1'b0;
                end
            end
        end
    end

    // Event enable register.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evt_enable <= RESET_EVT;
        end else if (wr_evt_en) begin
            evt_enable <= reg_wdata[EVT_WIDTH-1:0];
        end
    end

    // Level interrupt line from enabled event status.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_line <= 1'b0;
        end else begin
            irq_line <= |(evt_status & evt_enable);
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        if (reg_addr == OFF_CORE_IRQ_CONTROL) begin
            next_rdata = core_ctrl;
        end else if (reg_addr == OFF_ENABLE_1) begin
            next_rdata = en_1;
        end else if (reg_addr == OFF_ENABLE_2) begin
            next_rdata = en_2;
        end else if (reg_addr == OFF_ENABLE_3) begin
            next_rdata = en_3;
        end else if (reg_addr == OFF_ENABLE_4) begin
            next_rdata = en_4;
        end else if (reg_addr == OFF_REQUEST_1) begin
            next_rdata = rq_1;
        end else if (reg_addr == OFF_REQUEST_2) begin
            next_rdata = rq_2;
        end else if (reg_addr == OFF_REQUEST_3) begin
            next_rdata = rq_3;
        end else if (reg_addr == OFF_REQUEST_4) begin
            next_rdata = rq_4;
        end else if (reg_addr == OFF_EVT_STATUS) begin
            next_rdata = {6'h00, evt_status};
        end else if (reg_addr == OFF_EVT_ENABLE) begin
            next_rdata = {6'h00, evt_enable};
        end else begin
            next_rdata = 8'h00;
        end
    end

    // Read data stands the cycle after the read strobe only.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= RESET_BYTE;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= RESET_BYTE;
        end
    end

    property p_master_gate;
        @(posedge clk_sys) disable iff (rst)
        !core_ctrl[BIT_PERIPH_IRQ_MASTER_ENABLE] |=> !core_irq;
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("irq without master enable");

    property p_event_sets;
        @(posedge clk_sys) disable iff (rst)
        event_2[7] |=> rq_2[7];
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event did not set flag");

    property p_unimpl_zero;
        @(posedge clk_sys) disable iff (rst)
        (rq_2 & ~IMPL_2) == 8'h00 && (en_3 & ~IMPL_3) == 8'h00 && (rq_4 & ~IMPL_4) == 8'h00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_ro_bits;
        @(posedge clk_sys) disable iff (rst)
        wr_r1 && event_1 == 8'h00 |=> rq_1[5:4] == $past(rq_1[5:4]);
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only flag written");

    property p_busy_low;
        @(posedge clk_sys) disable iff (rst)
        serial2_busy && !event_4[0] |=> !rq_4[0];
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("event flag set while busy");

    property p_global_gate;
        @(posedge clk_sys) disable iff (rst)
        !core_ctrl[BIT_GLOBAL_IRQ_ENABLE] |=> !core_irq;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("irq with global clear");

    property p_vector;
        @(posedge clk_sys) disable iff (rst)
        taken |=> vector_addr == IRQ_VECTOR ##1 !core_irq;
    endproperty
    a_vector: assert property (p_vector) else $error("vector not presented");

    property p_request_follows;
        @(posedge clk_sys) disable iff (rst)
        periph_pending && core_ctrl[7:6] == 2'b11 && !taken |=> core_irq;
    endproperty
    a_request_follows: assert property (p_request_follows) else $error("missing request");

    property p_sw_set;
        @(posedge clk_sys) disable iff (rst)
        wr_r2 && reg_wdata[7] |=> rq_2[7];
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("software set failed");

endmodule // pirq_unit

// file: sim/pirq_core_model.sv
// Core-side partner model that accepts interrupt requests after a chosen delay.
`timescale 1ns/100ps
module pirq_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic core_irq,
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    output logic irq_ack
);
    logic [3:0] wait_count;

    // Counts the cycles of a standing request, then accepts it with a one-cycle pulse.
    always_ff @(posedge clk_sys) begin
        if (rst || !core_irq || irq_ack) begin
            wait_count <= 4'h0;
            irq_ack <= 1'b0;
        end else if (ack_en && wait_count == ack_delay) begin
            irq_ack <= 1'b1;
        end else if (ack_en) begin
            wait_count <= wait_count + 4'h1;
        end
    end
endmodule // pirq_core_model

// file: sim/tb_top.sv
// Self-checking testbench of the peripheral interrupt unit, both variants.
`timescale 1ns/100ps
module tb_top;
    import pirq_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] ev [4] = '{default: 8'h00};
    logic serial2_busy = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_delay = 4'h0;
    logic irq_ack, core_irq, irq_line;
    logic [15:0] vector_addr;
    logic [7:0] reg_rdata, rdata_s, rd, rd_s, v;
    logic [7:0] mask [4] = '{MASK_REG_1, MASK_REG_2, MASK_REG_3, MASK_REG_4};
    logic [7:0] smask [4] = '{MASK_REG_1, MASK_REG_2 & ~LARGE_ONLY_2, 8'h00, 8'h00};
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int n;

    pirq_unit #(.LARGE_VARIANT(1'b1)) dut_u (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .event_1(ev[0]), .event_2(ev[1]),
        .event_3(ev[2]), .event_4(ev[3]), .serial2_busy(serial2_busy), .irq_ack(irq_ack),
        .core_irq(core_irq), .vector_addr(vector_addr), .irq_line(irq_line));
    pirq_unit #(.LARGE_VARIANT(1'b0)) dut_s (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(rdata_s), .event_1(ev[0]), .event_2(ev[1]),
        .event_3(ev[2]), .event_4(ev[3]), .serial2_busy(serial2_busy), .irq_ack(1'b0),
        .core_irq(), .vector_addr(), .irq_line());
    pirq_core_model core_u (.clk_sys(clk_sys), .rst(rst), .core_irq(core_irq),
        .ack_en(ack_en), .ack_delay(ack_delay), .irq_ack(irq_ack));

    // Free-running system clock at 50 MHz.
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rdr(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
        rd_s = rdata_s;
    endtask

    task automatic pulse(input int k, input logic [7:0] d);
        @(posedge clk_sys);
        ev[k] <= d;
        @(posedge clk_sys);
        ev[k] <= 8'h00;
    endtask

    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 12 && core_irq !== lvl; i++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    // Writable request bits of register k, from the layout masks.
    function automatic logic [7:0] req_wr(input int k);
        return mask[k] & ((k == 0) ? ~READ_ONLY_REQ_1 : 8'hff);
    endfunction

    // Main sequence: reset values, layouts, events, gating, vector, status, busy hold.
    initial begin
        void'($urandom(32'h093ee47c));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a < 14; a++) begin
            rdr(4'(a));
            check("reset read", {rd_s, rd}, 16'h0000);
        end
        for (int k = 0; k < 4; k++) begin
            wr(4'(OFF_ENABLE_1 + k), 8'hff);
            rdr(4'(OFF_ENABLE_1 + k));
            check("enable", {rd_s, rd}, {smask[k], mask[k]});
            wr(4'(OFF_ENABLE_1 + k), 8'h00);
            rdr(4'(OFF_ENABLE_1 + k));
            check("enable off", rd, 8'h00);
            wr(4'(OFF_REQUEST_1 + k), 8'hff);
            rdr(4'(OFF_REQUEST_1 + k));
            check("request write", rd, req_wr(k));
            check("small request", rd_s, smask[k] & req_wr(k));
            wr(4'(OFF_REQUEST_1 + k), 8'h00);
            rdr(4'(OFF_REQUEST_1 + k));
            check("request clear", rd, 8'h00);
        end
        repeat (10) begin
            n = $urandom_range(3);
            v = 8'($urandom) & ((n == 0) ? ~READ_ONLY_REQ_1 : 8'hff);
            pulse(n, v);
            rdr(4'(OFF_REQUEST_1 + n));
            check("event flag", rd, v & mask[n]);
            wr(4'(OFF_REQUEST_1 + n), 8'h00);
        end
        wr(OFF_ENABLE_2, 8'h80);
        pulse(1, 8'h80);
        wr(OFF_EVT_ENABLE, 8'h01);
        ack_en <= 1'b1;
        wr(OFF_CORE_IRQ_CONTROL, 8'h80);
        repeat (3) @(posedge clk_sys);
        #1;
        check("no master", core_irq, 1'b0);
        wr(OFF_CORE_IRQ_CONTROL, 8'h40);
        repeat (3) @(posedge clk_sys);
        #1;
        check("no global", core_irq, 1'b0);
        wr(OFF_CORE_IRQ_CONTROL, 8'hc0);
        wait_irq(1'b1);
        check("request up", core_irq, 1'b1);
        wait_irq(1'b0);
        check("vector", vector_addr, IRQ_VECTOR);
        rdr(OFF_CORE_IRQ_CONTROL);
        check("global after take", rd, 8'h40);
        check("event line", irq_line, 1'b1);
        rdr(OFF_EVT_STATUS);
        check("taken status", rd, 8'h03);
        wr(OFF_EVT_CLEAR, 8'h03);
        rdr(OFF_EVT_STATUS);
        check("status clear", {irq_line, rd}, 9'h000);
        ack_delay <= 4'h3;
        wr(OFF_CORE_IRQ_CONTROL, 8'hc0);
        wait_irq(1'b1);
        check("held request", core_irq, 1'b1);
        wait_irq(1'b0);
        check("slow take", core_irq, 1'b0);
        @(posedge clk_sys);
        serial2_busy <= 1'b1;
        pulse(3, 8'h03);
        rdr(OFF_REQUEST_4);
        check("busy hold", rd, 8'h02);
        @(posedge clk_sys);
        serial2_busy <= 1'b0;
        pulse(3, 8'h01);
        rdr(OFF_REQUEST_4);
        check("serial2 flags", rd, 8'h03);
        pulse(0, READ_ONLY_REQ_1);
        wr(OFF_REQUEST_1, 8'h00);
        rdr(OFF_REQUEST_1);
        check("read-only flags", rd, READ_ONLY_REQ_1);
        final_report();
    end
endmodule // tb_top
